// *** src/fndc_core.sv ***
// fndc_core.sv: divider control of a fractional-N synthesizer: registers,
// reference divider, delta-sigma modulated feedback divider, phase detector.
// assumes the serial port has already decoded writes into wr_en/addr/data
// and that ref_tick / rf_tick are single-cycle edges of the undivided inputs.
// Summary of operation
// - reference divider ratio 1..16383, 14-bit field
// - reference divider valid up to 250MHz
// - phase detector drives charge pump up/down
// - loop type bit sets charge pump polarity
// - one bit selects high-gain pump mode
// - fvco = fref/R * prescale * (N+frac/2^24)
// - prescale select: 1 halves, 0 bypasses
// - N in 19-bit field, fraction 24-bit
// - exact ratio defaults zero, adds nothing
// - exact numerator high 12, denominator low
// - 19-bit multi-modulus divider after prescaler
// - bypass: integer ratios 16..524287
// - halved: ratios 32..1048574, even only
// - fraction write applies setting, starts tuning
`timescale 1ns/1ps
`default_nettype none
`include "fndc_params.svh"
module fndc_core
  import fndc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [23:0] wr_data,
  input  wire logic [4:0]  rd_addr,
  output logic      [23:0] rd_data,
  input  wire logic        ref_tick,
  input  wire logic        rf_tick,
  output logic             charge_pump_up,
  output logic             charge_pump_dn,
  output logic             charge_pump_high_gain,
  output logic             tune_start,
  output logic             tune_busy,
  output logic      [19:0] active_ratio
);
  // programmed fields
  logic [13:0] ref_ratio_r,  ref_ratio_nxt;   // reference divide ratio
  logic [18:0] int_value_r,  int_value_nxt;   // written N, staged
  logic [23:0] frac_r,       frac_nxt;        // fraction numerator
  logic [23:0] exact_r,      exact_nxt;       // exact numerator/denominator
  logic        halve_r,      halve_nxt;       // prescale_halve_select
  logic        high_gain_r,  high_gain_nxt;   // charge pump gain mode
  logic        loop_inv_r,   loop_inv_nxt;    // active inverting filter
  // applied setting, only updated on a fraction write
  logic [18:0] n_act_r,      n_act_nxt;
  logic [23:0] frac_act_r,   frac_act_nxt;
  logic [23:0] exact_act_r,  exact_act_nxt;
  logic        halve_act_r,  halve_act_nxt;
  fndc_tune_t  tune_r,       tune_nxt;
  logic [7:0]  tune_cnt_r,   tune_cnt_nxt;    // settling wait in cycles

  // register writes; fraction write also triggers the apply
  always_comb
  begin
    ref_ratio_nxt = ref_ratio_r;
    int_value_nxt = int_value_r;
    frac_nxt      = frac_r;
    exact_nxt     = exact_r;
    halve_nxt     = halve_r;
    high_gain_nxt = high_gain_r;
    loop_inv_nxt  = loop_inv_r;
    if (wr_en)
    begin
      case (wr_addr)
        `FNDC_ADDR_REF_RATIO:   ref_ratio_nxt = wr_data[13:0];
        `FNDC_ADDR_INT_VALUE:   int_value_nxt = wr_data[18:0];
        `FNDC_ADDR_FRAC_NUM:    frac_nxt      = wr_data;
        `FNDC_ADDR_EXACT_RATIO: exact_nxt     = wr_data;
        `FNDC_ADDR_PRESCALE:
          halve_nxt = wr_data[`FNDC_BIT_PRESCALE];
        `FNDC_ADDR_PUMP_GAIN:
          high_gain_nxt = wr_data[`FNDC_BIT_HIGH_GAIN];
        `FNDC_ADDR_LOOP_TYPE:
          loop_inv_nxt = wr_data[`FNDC_BIT_LOOP_TYPE];
        default: ;  // other addresses belong to other blocks
      endcase
    end
  end

  // apply and tuning sequence; busy waits a fixed settling count
  always_comb
  begin
    n_act_nxt     = n_act_r;
    frac_act_nxt  = frac_act_r;
    exact_act_nxt = exact_act_r;
    halve_act_nxt = halve_act_r;
    tune_nxt      = tune_r;
    tune_cnt_nxt  = tune_cnt_r;
    if (wr_en && wr_addr == `FNDC_ADDR_FRAC_NUM)
    begin
      // new frequency takes effect only here, so N alone never glitches
      n_act_nxt     = int_value_r;
      frac_act_nxt  = wr_data;
      exact_act_nxt = exact_r;
      halve_act_nxt = halve_r;
      tune_nxt      = FNDC_TUNE_APPLY;
      tune_cnt_nxt  = `FNDC_TUNE_WAIT;
    end
    else
    begin
      case (tune_r)
        FNDC_TUNE_IDLE:  tune_nxt = FNDC_TUNE_IDLE;
        FNDC_TUNE_APPLY: tune_nxt = FNDC_TUNE_RUN;
        FNDC_TUNE_RUN:
        begin
          if (tune_cnt_r == 8'h00)
            tune_nxt = FNDC_TUNE_IDLE;
          else
            tune_cnt_nxt = tune_cnt_r - 8'h01;
        end
        default: tune_nxt = FNDC_TUNE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_ratio_r <= `FNDC_RST_REF_RATIO;
      int_value_r <= `FNDC_RST_INT_VALUE;
      frac_r      <= `FNDC_RST_FRAC;
      exact_r     <= `FNDC_RST_EXACT;
      halve_r     <= 1'b0;
      high_gain_r <= 1'b0;
      loop_inv_r  <= 1'b0;
      n_act_r     <= `FNDC_RST_INT_VALUE;
      frac_act_r  <= `FNDC_RST_FRAC;
      exact_act_r <= `FNDC_RST_EXACT;
      halve_act_r <= 1'b0;
      tune_r      <= FNDC_TUNE_IDLE;
      tune_cnt_r  <= 8'h00;
    end
    else
    begin
      ref_ratio_r <= ref_ratio_nxt;
      int_value_r <= int_value_nxt;
      frac_r      <= frac_nxt;
      exact_r     <= exact_nxt;
      halve_r     <= halve_nxt;
      high_gain_r <= high_gain_nxt;
      loop_inv_r  <= loop_inv_nxt;
      n_act_r     <= n_act_nxt;
      frac_act_r  <= frac_act_nxt;
      exact_act_r <= exact_act_nxt;
      halve_act_r <= halve_act_nxt;
      tune_r      <= tune_nxt;
      tune_cnt_r  <= tune_cnt_nxt;
    end
  end

  // read back of the programmed fields, zero elsewhere
  always_comb
  begin
    case (rd_addr)
      `FNDC_ADDR_REF_RATIO:   rd_data = {10'h000, ref_ratio_r};
      `FNDC_ADDR_INT_VALUE:   rd_data = {5'h00, int_value_r};
      `FNDC_ADDR_FRAC_NUM:    rd_data = frac_r;
      `FNDC_ADDR_EXACT_RATIO: rd_data = exact_r;
      `FNDC_ADDR_PRESCALE:    rd_data = {4'h0, halve_r, 19'h00000};
      `FNDC_ADDR_PUMP_GAIN:   rd_data = {high_gain_r, 23'h000000};
      `FNDC_ADDR_LOOP_TYPE:   rd_data = {19'h00000, loop_inv_r, 4'h0};
      default:                rd_data = 24'h000000;
    endcase
  end

  // reference divider: ref_tick is the buffered reference, limited upstream
  // to the 250MHz figure; here it is one edge per clock at most
  logic ref_div_tick;
  fndc_counter_div #(.W(14)) u_ref_div
  (
    .clock    (clock),
    .arst_n   (arst_n),
    .in_tick  (ref_tick),
    .ratio    (ref_ratio_r),
    .out_tick (ref_div_tick)
  );

  // prescaler: toggle divides rf edges by two when selected
  logic pre_r, pre_nxt;
  logic pre_tick;
  always_comb
  begin
    pre_nxt  = pre_r;
    if (rf_tick && halve_act_r)
      pre_nxt = ~pre_r;
    pre_tick = rf_tick && (!halve_act_r || pre_r);
  end

  // second order error-feedback modulator on fraction plus exact part;
  // exact part adds frac carry when its accumulator passes the denominator
  logic [23:0] acc1_r, acc1_nxt;       // first stage accumulator
  logic [23:0] acc2_r, acc2_nxt;       // second stage accumulator
  logic [11:0] eacc_r, eacc_nxt;       // exact ratio accumulator
  logic        c1_r,   c1_nxt;         // delayed carry for differencing
  logic signed [3:0] ofs;              // per-cycle offset to N
  logic [24:0] s1, s2;
  logic [12:0] es;
  logic        ecarry;
  logic [11:0] e_num, e_den;
  logic [18:0] mmd_ratio;
  logic        fb_tick;

  always_comb
  begin
    e_num    = exact_act_r[23:`FNDC_EXACT_NUM_LSB];
    e_den    = exact_act_r[11:0];
    // zero denominator is imprecise mode: exact term contributes nothing
    es       = {1'b0, eacc_r} + {1'b0, e_num};
    ecarry   = (e_den != 12'h000) && (es >= {1'b0, e_den});
    eacc_nxt = eacc_r;
    acc1_nxt = acc1_r;
    acc2_nxt = acc2_r;
    c1_nxt   = c1_r;
    s1 = {1'b0, acc1_r} + {1'b0, frac_act_r} + {24'h000000, ecarry};
    s2 = {1'b0, acc2_r} + {1'b0, s1[23:0]};
    // offset = c1 + c2 - c2 delayed, kept within -4..+3
    ofs = $signed({3'b000, s1[24]}) + $signed({3'b000, s2[24]})
          - $signed({3'b000, c1_r});
    // clamp to the modulator's legal offset window
    if (ofs < 4'(`FNDC_DSM_OFS_MIN))
      ofs = 4'(`FNDC_DSM_OFS_MIN);
    else if (ofs > 4'(`FNDC_DSM_OFS_MAX))
      ofs = 4'(`FNDC_DSM_OFS_MAX);
    if (fb_tick)
    begin
      eacc_nxt = ecarry ? 12'(es - {1'b0, e_den}) : es[11:0];
      acc1_nxt = s1[23:0];
      acc2_nxt = s2[23:0];
      c1_nxt   = s2[24];
    end
    // N plus offset per output cycle, floored at the smallest modulus
    mmd_ratio = 19'($signed({1'b0, n_act_r}) + 20'(ofs));
    if (mmd_ratio < `FNDC_FB_MIN)
      mmd_ratio = `FNDC_FB_MIN;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pre_r  <= 1'b0;
      acc1_r <= 24'h000000;
      acc2_r <= 24'h000000;
      eacc_r <= 12'h000;
      c1_r   <= 1'b0;
    end
    else
    begin
      pre_r  <= pre_nxt;
      acc1_r <= acc1_nxt;
      acc2_r <= acc2_nxt;
      eacc_r <= eacc_nxt;
      c1_r   <= c1_nxt;
    end
  end

  // multi-modulus feedback divider, ratio refreshed every output cycle
  fndc_counter_div #(.W(19)) u_fb_div
  (
    .clock    (clock),
    .arst_n   (arst_n),
    .in_tick  (pre_tick),
    .ratio    (mmd_ratio),
    .out_tick (fb_tick)
  );

  // phase detector: earlier edge opens pump pulse, the other closes it
  fndc_pd_t pd_r, pd_nxt;
  always_comb
  begin
    pd_nxt = pd_r;
    case (pd_r)
      FNDC_PD_IDLE:
        if (ref_div_tick && !fb_tick)
          pd_nxt = FNDC_PD_UP;
        else if (fb_tick && !ref_div_tick)
          pd_nxt = FNDC_PD_DN;
      FNDC_PD_UP: if (fb_tick)      pd_nxt = FNDC_PD_IDLE;
      FNDC_PD_DN: if (ref_div_tick) pd_nxt = FNDC_PD_IDLE;
      default: pd_nxt = FNDC_PD_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      pd_r <= FNDC_PD_IDLE;
    else
      pd_r <= pd_nxt;
  end

  // inverting filter swaps the pump direction
  assign charge_pump_up = (pd_r == FNDC_PD_UP) ^ ((pd_r != FNDC_PD_IDLE)
                          && loop_inv_r);
  assign charge_pump_dn = (pd_r == FNDC_PD_DN) ^ ((pd_r != FNDC_PD_IDLE)
                          && loop_inv_r);
  assign charge_pump_high_gain = high_gain_r;
  assign tune_start   = (tune_r == FNDC_TUNE_APPLY);
  assign tune_busy    = (tune_r != FNDC_TUNE_IDLE);
  assign active_ratio = halve_act_r ? {n_act_r, 1'b0} : {1'b0, n_act_r};
endmodule
`default_nettype wire

// *** src/fndc_counter_div.sv ***
// fndc_counter_div.sv: programmable divide-by-ratio counter, one pulse out
// per ratio input edges. assumes in_tick is one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module fndc_counter_div
#(
  parameter int W = 14
)
(
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         in_tick,   // one input edge
  input  wire logic [W-1:0] ratio,     // divide ratio, zero treated as one
  output logic              out_tick   // one pulse per ratio edges
);
  logic [W-1:0] cnt_r;     // edges counted so far
  logic [W-1:0] cnt_nxt;
  logic         wrap;

  // wrap when the last edge of the ratio arrives
  always_comb
  begin
    wrap    = in_tick && (cnt_r + W'(1) >= ratio);
    cnt_nxt = cnt_r;
    if (wrap)
      cnt_nxt = '0;
    else if (in_tick)
      cnt_nxt = cnt_r + W'(1);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign out_tick = wrap;
endmodule
`default_nettype wire

// *** src/fndc_params.svh ***
// fndc_params.svh: register offsets, field positions, reset values and limits
// for the fractional-N divider control block; definitions only.
`ifndef FNDC_PARAMS_SVH
`define FNDC_PARAMS_SVH

// register word addresses on the serial register port
`define FNDC_ADDR_REF_RATIO    5'h02
`define FNDC_ADDR_INT_VALUE    5'h03
`define FNDC_ADDR_FRAC_NUM     5'h04
`define FNDC_ADDR_PRESCALE     5'h08
`define FNDC_ADDR_PUMP_GAIN    5'h09
`define FNDC_ADDR_LOOP_TYPE    5'h0B
`define FNDC_ADDR_EXACT_RATIO  5'h0C

// field positions
`define FNDC_BIT_PRESCALE      19
`define FNDC_BIT_HIGH_GAIN     23
`define FNDC_BIT_LOOP_TYPE     4
`define FNDC_EXACT_NUM_LSB     12

// reset values
`define FNDC_RST_REF_RATIO     14'h0001
`define FNDC_RST_INT_VALUE     19'h00010
`define FNDC_RST_FRAC          24'h000000
`define FNDC_RST_EXACT         24'h000000

// limits of the dividers
`define FNDC_REF_MIN           14'h0001
`define FNDC_FB_MIN            19'h00010
`define FNDC_DSM_OFS_MIN       (-4)
`define FNDC_DSM_OFS_MAX       3

// settling wait loaded on a fraction write, in clock cycles
`define FNDC_TUNE_WAIT         8'hFF

// reference input limit, and the sampling clock
`define FNDC_REF_MAX_MHZ       250
`define FNDC_CLK_MHZ           20

`endif

// *** src/fndc_pkg.sv ***
// fndc_pkg.sv: types shared by the divider control files.
// assumes fndc_params.svh is on the include path.
package fndc_pkg;
  // phase detector output code toward the charge pump
  typedef enum logic [1:0]
  {
    FNDC_PD_IDLE = 2'h0,
    FNDC_PD_UP   = 2'h1,
    FNDC_PD_DN   = 2'h2
  } fndc_pd_t;
  // tuning sequence after a fraction write
  typedef enum logic [1:0]
  {
    FNDC_TUNE_IDLE  = 2'h0,
    FNDC_TUNE_APPLY = 2'h1,
    FNDC_TUNE_RUN   = 2'h3
  } fndc_tune_t;
endpackage

// *** tb/fndc_core_checker.sv ***
// checker for the divider control block, sees top ports only.
// assumes one clock domain with async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fndc_core_checker
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [23:0] wr_data,
  input  wire logic [4:0]  rd_addr,
  input  wire logic [23:0] rd_data,
  input  wire logic        charge_pump_up,
  input  wire logic        charge_pump_dn,
  input  wire logic        charge_pump_high_gain,
  input  wire logic        tune_start,
  input  wire logic        tune_busy,
  input  wire logic [19:0] active_ratio
);
  logic [8:0] busy_cnt_r;   // cycles since last tune start, saturates
  logic [8:0] busy_cnt_nxt; // next count
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // count up from a start; saturating avoids wrap faking a new window
  always_comb
  begin
    busy_cnt_nxt = busy_cnt_r;
    if (tune_start)
      busy_cnt_nxt = 9'h001;
    else if (busy_cnt_r != 9'h000 && busy_cnt_r < 9'h12C)
      busy_cnt_nxt = busy_cnt_r + 9'h001;
  end
  // register the count
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      busy_cnt_r <= 9'h000;
    else
      busy_cnt_r <= busy_cnt_nxt;
  end
  chk_tune_pulse: assert property (
    wr_en && wr_addr == 5'h04 |=> tune_start)
    else $error("no tune start after fraction write");
  chk_tune_single: assert property (
    tune_start && !(wr_en && wr_addr == 5'h04) |=> !tune_start)
    else $error("tune start longer than one cycle");
  chk_busy_start: assert property (
    tune_start |-> tune_busy ##1 tune_busy[*8])
    else $error("busy not raised with tune start");
  chk_busy_len: assert property (
    busy_cnt_r != 9'h000 && !tune_start
    |-> tune_busy == (busy_cnt_r < 9'h101))
    else $error("busy length wrong");
  chk_gain_set: assert property (
    wr_en && wr_addr == 5'h09
    |=> charge_pump_high_gain == $past(wr_data[23]))
    else $error("high gain not taken from bit 23");
  chk_gain_hold: assert property (
    !(wr_en && wr_addr == 5'h09) |=> $stable(charge_pump_high_gain))
    else $error("high gain moved without write");
  chk_ratio_hold: assert property (
    !(wr_en && wr_addr == 5'h04) |=> $stable(active_ratio))
    else $error("ratio applied without fraction write");
  chk_ratio_floor: assert property (
    active_ratio >= 20'h00010)
    else $error("applied ratio below sixteen");
  chk_pump_excl: assert property (
    !(charge_pump_up && charge_pump_dn))
    else $error("pump up and down together");
  chk_ref_width: assert property (
    rd_addr == 5'h02 |-> rd_data[23:14] == 10'h000)
    else $error("reference ratio wider than 14 bits");
endmodule
bind fndc_core fndc_core_checker u_chk
(
  .clock                 (clock),
  .arst_n                (arst_n),
  .wr_en                 (wr_en),
  .wr_addr               (wr_addr),
  .wr_data               (wr_data),
  .rd_addr               (rd_addr),
  .rd_data               (rd_data),
  .charge_pump_up        (charge_pump_up),
  .charge_pump_dn        (charge_pump_dn),
  .charge_pump_high_gain (charge_pump_high_gain),
  .tune_start            (tune_start),
  .tune_busy             (tune_busy),
  .active_ratio          (active_ratio)
);
`default_nettype wire

// *** tb/fndc_core_tb.sv ***
// testbench for the divider control block: register table, ratios,
// tuning window and phase detector; host model makes the writes.
`timescale 1ns/1ps
`default_nettype none
module fndc_core_tb;
  logic        clock = 1'b0;        // 20 MHz
  logic        arst_n = 1'b0;       // held low at start
  logic        ref_tick = 1'b0;     // reference edge
  logic        rf_tick = 1'b0;      // rf edge
  logic [4:0]  rd_addr = 5'h00;     // read select
  logic        wr_en;               // from host model
  logic [4:0]  wr_addr;
  logic [23:0] wr_data;
  logic [23:0] rd_data;
  logic        charge_pump_up;
  logic        charge_pump_dn;
  logic        charge_pump_high_gain;
  logic        tune_start;
  logic        tune_busy;
  logic [19:0] active_ratio;
  int          miscompares = 0;
  int          n_tests = 0;
  int          n;
  // rows: address, data written, value read back (masked, unmapped 0)
  logic [4:0]  t_a [9] = '{5'h02, 5'h03, 5'h04, 5'h0C, 5'h08, 5'h09,
                           5'h0B, 5'h05, 5'h0E};
  logic [23:0] t_d [9] = '{24'hFFFFFF, 24'hFFFFFF, 24'hABCDEF, 24'h3E8BB8,
                           24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF, 24'h123456,
                           24'h654321};
  logic [23:0] t_e [9] = '{24'h003FFF, 24'h07FFFF, 24'hABCDEF, 24'h3E8BB8,
                           24'h080000, 24'h800000, 24'h000010, 24'h000000,
                           24'h000000};
  always #25 clock = ~clock;
  fndc_host_model u_fndc_host_model
  (
    .clock   (clock),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data)
  );
  fndc_core u_fndc_core
  (
    .clock                 (clock),
    .arst_n                (arst_n),
    .wr_en                 (wr_en),
    .wr_addr               (wr_addr),
    .wr_data               (wr_data),
    .rd_addr               (rd_addr),
    .rd_data               (rd_data),
    .ref_tick              (ref_tick),
    .rf_tick               (rf_tick),
    .charge_pump_up        (charge_pump_up),
    .charge_pump_dn        (charge_pump_dn),
    .charge_pump_high_gain (charge_pump_high_gain),
    .tune_start            (tune_start),
    .tune_busy             (tune_busy),
    .active_ratio          (active_ratio)
  );
  // compare and count
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // single place where the run ends
  task automatic report_and_stop;
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // read port is combinational; settle before looking
  task automatic rd(input logic [4:0] a, input logic [23:0] exp);
    @(negedge clock);
    rd_addr = a;
    #1;
    chk(rd_data, exp);
  endtask
  // one edge pulse, then two cycles for the detector to react
  task automatic tick(input bit rf);
    @(negedge clock);
    if (rf)
      rf_tick = 1'b1;
    else
      ref_tick = 1'b1;
    @(negedge clock);
    rf_tick = 1'b0;
    ref_tick = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  // ref first opens a pulse; rf edges close it, counted with a bound
  task automatic pd_check(input bit inv);
    tick(1'b0);
    chk({23'h0, charge_pump_up}, {23'h0, !inv});
    chk({23'h0, charge_pump_dn}, {23'h0, inv});
    n = 0;
    while ((charge_pump_up | charge_pump_dn) !== 1'b0 && n < 40)
    begin
      tick(1'b1);
      n++;
    end
    if (n >= 40)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask
  initial
  begin
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    rd(5'h02, 24'h000001);
    rd(5'h0C, 24'h000000);
    chk({4'h0, active_ratio}, 24'h000010);
    pd_check(1'b0);
    chk(24'(n), 24'h000010);
    for (int i = 0; i < 9; i++)
    begin
      u_fndc_host_model.wr(t_a[i], t_d[i]);
      rd(t_a[i], t_e[i]);
    end
    chk({23'h0, charge_pump_high_gain}, 24'h000001);
    u_fndc_host_model.wr(5'h08, 24'h080000);
    chk({4'h0, active_ratio}, 24'h07FFFF);
    u_fndc_host_model.wr(5'h04, 24'h000000);
    chk({23'h0, tune_start}, 24'h000001);
    chk({4'h0, active_ratio}, 24'h0FFFFE);
    n = 0;
    while (tune_busy === 1'b1 && n < 400)
    begin
      @(negedge clock);
      n++;
    end
    chk(24'(n), 24'h000101);
    u_fndc_host_model.wr(5'h02, 24'h000001);
    u_fndc_host_model.wr(5'h0C, 24'h000000);
    u_fndc_host_model.wr(5'h08, 24'h000000);
    u_fndc_host_model.wr(5'h03, 24'h000010);
    u_fndc_host_model.wr(5'h0B, 24'h000010);
    u_fndc_host_model.wr(5'h04, 24'h000000);
    chk({4'h0, active_ratio}, 24'h000010);
    pd_check(1'b1);
    // non-unit ratio first, so the reset value is really seen
    u_fndc_host_model.wr(5'h02, 24'h000005);
    @(negedge clock);
    arst_n = 1'b0;
    rd(5'h03, 24'h000010);
    rd(5'h02, 24'h000001);
    chk({23'h0, tune_busy}, 24'h000000);
    arst_n = 1'b1;
    repeat (2) @(negedge clock);
    chk({4'h0, active_ratio}, 24'h000010);
    chk({23'h0, charge_pump_high_gain}, 24'h000000);
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** tb/fndc_host_model.sv ***
// host side model: issues register writes one word at a time.
// assumes the block samples writes on the rising edge of clock.
`timescale 1ns/1ps
`default_nettype none
module fndc_host_model
(
  input  wire logic        clock,
  output var  logic        wr_en,
  output var  logic [4:0]  wr_addr,
  output var  logic [23:0] wr_data
);
  // idle bus at time zero
  initial
  begin
    wr_en   = 1'b0;
    wr_addr = 5'h00;
    wr_data = 24'h000000;
  end
  // one write: strobe for exactly one rising edge, fields held meanwhile;
  // callers keep ratios in range, even when halved, and may write other fields after 0x04
  // pump currents are set outside this block; the core clamps the modulator offset
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(negedge clock);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clock);
    wr_en   = 1'b0;
    wr_data = ~d; // stale data is not left on the lines
  endtask
endmodule
`default_nettype wire
